// >>> hdl/aowdt_timer.v
// Function
// - Hold a 31-bit up-counter; bit 31 of the count reads as zero.
// - Counter runs on the slow clock, at most one step per cycle.
// - Increment by one only if an enabled condition is true, else hold.
// - Run-always bit makes the counter increment every cycle.
// - Run-while-awake bit increments only while core reset is not held.
// - Reset clears both run enables and the reset-fire enable.
// - Scaled count is the 16-bit slice starting at scale_select.
// - Scale zero gives the low bits; scale 15 divides by 2^15.
// - Scaled count is readable as one read-only 16-bit value.
// - Comparator asserts whenever scaled count is at or above threshold.
// - With auto-zero set, counter clears one cycle after comparator asserts.
// - Only with reset-fire enabled may the comparator request chip reset.
// - With reset-fire enabled, an unfed counter reaching threshold sends a reset request out.
// - Comparator output sets sticky match_pending, which flags an interrupt.
// - Software reads and writes match_pending, clearing it after unlock.
// - Writing 0x51F15E to the unlock address sets the unlock latch.
// - Unlock latch clears on reset and after any watchdog register write.
// - All registers readable at any time regardless of the latch.
// - Unlocked write of 0xD09F00D to feed port zeroes the counter.
// - Feed port holds no state and reads as zero.
// - Counter is readable and writable, writes needing unlock.
// - Reset request is one source of the widest always-on reset.
`timescale 1ns/1ps
`include "aowdt_regs.vh"

module aowdt_timer #(
   parameter CW = `AOWDT_COUNT_W,
   parameter SW = `AOWDT_SCALED_W,
   parameter AW = `AOWDT_ADDR_W
) (
   input  wire          clk,
   input  wire          nrst,
   input  wire          core_held_reset,
   input  wire          reg_sel,
   input  wire          reg_wr,
   input  wire [AW-1:0] reg_addr,
   input  wire [31:0]   reg_wdata,
   output reg  [31:0]   reg_rdata,
   output reg           reg_ack,
   output reg           match_pending_irq,
   output reg           guard_reset_req,
   output reg           unlocked,
   output reg           write_ignored
);

   // Configuration state
   reg [`AOWDT_SCALE_W-1:0] scale_q;
   reg [`AOWDT_SCALE_W-1:0] scale_d;
   reg                      rst_en_q;
   reg                      rst_en_d;
   reg                      auto_zero_q;
   reg                      auto_zero_d;
   reg                      run_always_q;
   reg                      run_always_d;
   reg                      run_awake_q;
   reg                      run_awake_d;
   reg                      pending_q;
   reg                      pending_d;

   // Counter, threshold and key latch
   reg [CW-1:0]             count_q;
   reg [CW-1:0]             count_d;
   reg [SW-1:0]             thr_q;
   reg [SW-1:0]             thr_d;
   reg                      unlock_q;
   reg                      unlock_d;

   // Bus answer and reset request
   reg [31:0]               rdata_d;
   reg                      fire_d;
   reg                      ignored_d;

   // Decode
   wire                     wr_any;
   wire                     rd_any;
   wire                     hit_cfg;
   wire                     hit_cnt;
   wire                     hit_scl;
   wire                     hit_feed;
   wire                     hit_key;
   wire                     hit_thr;
   wire                     hit_prot;
   wire                     wr_ok;
   wire                     key_match;
   wire                     feed_match;

   // Counter datapath and configuration view
   wire                     inc_en;
   wire [SW-1:0]            scaled;
   wire                     cmp_hit;
   wire [31:0]              cfg_view;

   // Address decode; scaled count is read-only, so not a protected target
   assign wr_any   = reg_sel & reg_wr;
   assign rd_any   = reg_sel & ~reg_wr;
   assign hit_cfg  = (reg_addr == `AOWDT_OFS_CONFIG);
   assign hit_cnt  = (reg_addr == `AOWDT_OFS_COUNT);
   assign hit_scl  = (reg_addr == `AOWDT_OFS_SCALED);
   assign hit_feed = (reg_addr == `AOWDT_OFS_FEED);
   assign hit_key  = (reg_addr == `AOWDT_OFS_UNLOCK);
   assign hit_thr  = (reg_addr == `AOWDT_OFS_THRESHOLD);
   assign hit_prot = hit_cfg | hit_cnt | hit_feed | hit_thr;

   // A protected write lands only when the latch was set beforehand
   assign wr_ok      = wr_any & hit_prot & unlock_q;
   assign key_match  = (reg_wdata == `AOWDT_UNLOCK_VALUE);
   assign feed_match = (reg_wdata == `AOWDT_FEED_VALUE);

   // Increment qualifiers; the core counts as asleep while held in reset
   assign inc_en = run_always_q |
                   (run_awake_q & ~core_held_reset);

   // Window select and compare live in their own leaf
   aowdt_scale_cmp #(
      .CW (CW),
      .SW (SW)
   ) u_scale_cmp (
      .count     (count_q),
      .scale     (scale_q),
      .threshold (thr_q),
      .scaled    (scaled),
      .hit       (cmp_hit)
   );

   // Configuration as software sees it; reserved bits stay zero
   assign cfg_view = {3'h0,
                      pending_q,
                      14'h0000,
                      run_awake_q,
                      run_always_q,
                      2'h0,
                      auto_zero_q,
                      rst_en_q,
                      4'h0,
                      scale_q};

   // Configuration next state
   always @* begin
      scale_d      = scale_q;
      rst_en_d     = rst_en_q;
      auto_zero_d  = auto_zero_q;
      run_always_d = run_always_q;
      run_awake_d  = run_awake_q;
      if (wr_ok && hit_cfg) begin
         scale_d      = reg_wdata[`AOWDT_CFG_SCALE_MSB:`AOWDT_CFG_SCALE_LSB];
         rst_en_d     = reg_wdata[`AOWDT_CFG_RST_EN];
         auto_zero_d  = reg_wdata[`AOWDT_CFG_AUTO_ZERO];
         run_always_d = reg_wdata[`AOWDT_CFG_RUN_ALWAYS];
         run_awake_d  = reg_wdata[`AOWDT_CFG_RUN_AWAKE];
      end
   end

   // Sticky pending bit; a match in the clearing cycle is never lost
   always @* begin
      pending_d = pending_q;
      if (wr_ok && hit_cfg) begin
         pending_d = reg_wdata[`AOWDT_CFG_PENDING];
      end
      if (cmp_hit) begin
         pending_d = 1'b1;
      end
   end

   // Counter next state: bus write, then feed, then auto-zero, then step.
   // Auto-zero acts at the edge after a hit, so the zero shows a cycle later.
   always @* begin
      count_d = count_q;
      if (wr_ok && hit_cnt) begin
         count_d = reg_wdata[CW-1:0];
      end else if (wr_ok && hit_feed && feed_match) begin
         count_d = `AOWDT_RST_COUNT;
      end else if (auto_zero_q && cmp_hit) begin
         count_d = `AOWDT_RST_COUNT;
      end else if (inc_en) begin
         count_d = count_q + {{(CW-1){1'b0}}, 1'b1};
      end
   end

   // Threshold next state; upper half of the word is reserved
   always @* begin
      thr_d = thr_q;
      if (wr_ok && hit_thr) begin
         thr_d = reg_wdata[SW-1:0];
      end
   end

   // Key latch: one unlock buys exactly one write to any watchdog register
   always @* begin
      unlock_d = unlock_q;
      if (wr_any && hit_key) begin
         unlock_d = key_match;
      end else if (wr_any && (hit_prot || hit_scl)) begin
         unlock_d = 1'b0;
      end
   end

   // Read mux; reads never depend on the latch
   always @* begin
      rdata_d = 32'h00000000;
      if (rd_any) begin
         case (reg_addr)
            `AOWDT_OFS_CONFIG: begin
               rdata_d = cfg_view;
            end
            `AOWDT_OFS_COUNT: begin
               rdata_d = {1'b0, count_q};
            end
            `AOWDT_OFS_SCALED: begin
               rdata_d = {16'h0000, scaled};
            end
            `AOWDT_OFS_FEED: begin
               rdata_d = 32'h00000000;
            end
            `AOWDT_OFS_UNLOCK: begin
               rdata_d = {31'h00000000, unlock_q};
            end
            `AOWDT_OFS_THRESHOLD: begin
               rdata_d = {16'h0000, thr_q};
            end
            default: begin
               rdata_d = 32'h00000000;
            end
         endcase
      end
   end

   // Reset request only with reset-fire enabled; the always-on reset it
   // causes clears this block too, so the request ends itself
   always @* begin
      fire_d = cmp_hit & rst_en_q;
   end

   // Flags a protected write dropped for lack of an unlock
   always @* begin
      ignored_d = wr_any & hit_prot & ~unlock_q;
   end

   // Configuration registers; run and fire enables come up cleared
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         scale_q      <= `AOWDT_RST_SCALE;
         rst_en_q     <= `AOWDT_RST_BIT;
         auto_zero_q  <= `AOWDT_RST_BIT;
         run_always_q <= `AOWDT_RST_BIT;
         run_awake_q  <= `AOWDT_RST_BIT;
      end else begin
         scale_q      <= scale_d;
         rst_en_q     <= rst_en_d;
         auto_zero_q  <= auto_zero_d;
         run_always_q <= run_always_d;
         run_awake_q  <= run_awake_d;
      end
   end

   // Sticky pending bit; kept apart so only the set and clear logic feed it
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pending_q <= `AOWDT_RST_BIT;
      end else begin
         pending_q <= pending_d;
      end
   end

   // Counter; a cleared count after reset means no stale interval survives
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         count_q <= `AOWDT_RST_COUNT;
      end else begin
         count_q <= count_d;
      end
   end

   // Threshold; comes up at its highest value so a stray start fires late
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         thr_q <= `AOWDT_RST_THRESHOLD;
      end else begin
         thr_q <= thr_d;
      end
   end

   // Key latch; starts locked so nothing changes before an unlock
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         unlock_q <= `AOWDT_RST_BIT;
      end else begin
         unlock_q <= unlock_d;
      end
   end

   // Read data; zero in cycles without a read, so no stale word lingers
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         reg_rdata <= 32'h00000000;
      end else begin
         reg_rdata <= rdata_d;
      end
   end

   // Acknowledge one cycle after every access, reads and writes alike
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         reg_ack <= 1'b0;
      end else begin
         reg_ack <= reg_sel;
      end
   end

   // Interrupt takes the pending bit's next value, so both change together
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         match_pending_irq <= 1'b0;
      end else begin
         match_pending_irq <= pending_d;
      end
   end

   // Reset request; the always-on reset it causes also clears it
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         guard_reset_req <= 1'b0;
      end else begin
         guard_reset_req <= fire_d;
      end
   end

   // Mirror of the key latch for software and checks
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         unlocked <= 1'b0;
      end else begin
         unlocked <= unlock_d;
      end
   end

   // One-cycle pulse for a protected write dropped while locked
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         write_ignored <= 1'b0;
      end else begin
         write_ignored <= ignored_d;
      end
   end

endmodule // aowdt_timer

// >>> hdl/aowdt_regs.vh
`ifndef AOWDT_REGS_VH
`define AOWDT_REGS_VH

// Register byte offsets
`define AOWDT_OFS_CONFIG      9'h000
`define AOWDT_OFS_COUNT       9'h008
`define AOWDT_OFS_SCALED      9'h010
`define AOWDT_OFS_FEED        9'h018
`define AOWDT_OFS_UNLOCK      9'h01c
`define AOWDT_OFS_THRESHOLD   9'h020

// Configuration field positions
`define AOWDT_CFG_SCALE_LSB   0
`define AOWDT_CFG_SCALE_MSB   3
`define AOWDT_CFG_RST_EN      8
`define AOWDT_CFG_AUTO_ZERO   9
`define AOWDT_CFG_RUN_ALWAYS  12
`define AOWDT_CFG_RUN_AWAKE   13
`define AOWDT_CFG_PENDING     28

// Widths
`define AOWDT_COUNT_W         31
`define AOWDT_SCALED_W        16
`define AOWDT_SCALE_W         4
`define AOWDT_ADDR_W          9

// Magic values
`define AOWDT_UNLOCK_VALUE    32'h0051f15e
`define AOWDT_FEED_VALUE      32'h0d09f00d

// Reset values
`define AOWDT_RST_COUNT       31'h00000000
`define AOWDT_RST_SCALE       4'h0
`define AOWDT_RST_THRESHOLD   16'hffff
`define AOWDT_RST_BIT         1'b0

// Nominal slow clock rate in Hz
`define AOWDT_SLOW_CLK_HZ     32768

`endif

// >>> hdl/aowdt_scale_cmp.v
`timescale 1ns/1ps
`include "aowdt_regs.vh"

// Picks the 16-bit window of the count and compares it with the threshold
module aowdt_scale_cmp #(
   parameter CW = `AOWDT_COUNT_W,
   parameter SW = `AOWDT_SCALED_W
) (
   input  wire [CW-1:0]             count,
   input  wire [`AOWDT_SCALE_W-1:0] scale,
   input  wire [SW-1:0]             threshold,
   output wire [SW-1:0]             scaled,
   output wire                      hit
);

   wire [CW-1:0] shifted;

   // Window starts at bit position scale; scale 15 divides by 2^15
   assign shifted = count >> scale;

   // One slice bit per output bit
   genvar i;
   generate
      for (i = 0; i < SW; i = i + 1) begin : g_slice
         assign scaled[i] = shifted[i];
      end
   endgenerate

   // Greater-or-equal, not just equal, so a jump past the threshold still fires
   assign hit = (scaled >= threshold);

endmodule // aowdt_scale_cmp

// >>> bench/aowdt_sleep_model.sv
`timescale 1ns/1ps
// Wakeup sequencer stand-in: holds the core in reset while asleep
module aowdt_sleep_model (
   input  logic clk,
   input  logic nrst,
   input  logic sleep_cmd,
   output logic core_held_reset
);
   // One edge of latency, as a registered sequencer output would have
   always @(posedge clk or negedge nrst) begin
      if (!nrst)
         core_held_reset <= 1'b0;
      else
         core_held_reset <= sleep_cmd;
   end
endmodule // aowdt_sleep_model

// >>> bench/aowdt_timer_properties.sv
`timescale 1ns/1ps
`include "aowdt_regs.vh"
// Port checks of the watchdog register block
module aowdt_props #(
   parameter CW = 31,
   parameter SW = 16,
   parameter AW = 9
) (
   input logic          clk,
   input logic          nrst,
   input logic          core_held_reset,
   input logic          reg_sel,
   input logic          reg_wr,
   input logic [AW-1:0] reg_addr,
   input logic [31:0]   reg_wdata,
   input logic [31:0]   reg_rdata,
   input logic          reg_ack,
   input logic          match_pending_irq,
   input logic          guard_reset_req,
   input logic          unlocked,
   input logic          write_ignored
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   // Decoded access kinds
   wire wr_any = reg_sel && reg_wr;
   wire rd_any = reg_sel && !reg_wr;
   wire a_cfg = reg_addr == `AOWDT_OFS_CONFIG;
   wire prot = a_cfg || reg_addr == `AOWDT_OFS_COUNT || reg_addr == `AOWDT_OFS_FEED
               || reg_addr == `AOWDT_OFS_THRESHOLD;
   wire key_ok = wr_any && reg_addr == `AOWDT_OFS_UNLOCK
                 && reg_wdata == `AOWDT_UNLOCK_VALUE;

   chk_ack_follows: assert property (reg_sel |=> reg_ack)
      else $error("access not answered");
   chk_key_sets: assert property (key_ok |=> unlocked)
      else $error("key did not unlock");
   chk_write_clears: assert property (
      wr_any && (prot || reg_addr == `AOWDT_OFS_SCALED) |=> !unlocked)
      else $error("latch kept after write");
   chk_locked_refuse: assert property (
      wr_any && prot && !unlocked |=> write_ignored)
      else $error("locked write not refused");
   chk_open_accept: assert property (
      wr_any && unlocked |=> !write_ignored)
      else $error("unlocked write refused");
   chk_feed_zero: assert property (
      rd_any && reg_addr == `AOWDT_OFS_FEED |=> reg_rdata == 32'h0)
      else $error("feed read not zero");
   chk_count_msb: assert property (
      rd_any && reg_addr == `AOWDT_OFS_COUNT |=> !reg_rdata[31])
      else $error("count bit 31 set");
   chk_cfg_spare: assert property (
      rd_any && a_cfg |=> (reg_rdata & 32'hefffccf0) == 32'h0)
      else $error("cfg spare bits");
   chk_cmp_spare: assert property (
      rd_any && reg_addr == `AOWDT_OFS_THRESHOLD |=> reg_rdata[31:16] == 16'h0)
      else $error("threshold spare bits");
   chk_pending_read: assert property (
      rd_any && a_cfg |=> reg_rdata[28] == $past(match_pending_irq))
      else $error("pending mismatch");
   chk_pending_sticky: assert property (
      $fell(match_pending_irq) |-> $past(wr_any && unlocked && a_cfg))
      else $error("pending lost");
endmodule // aowdt_props

bind aowdt_timer aowdt_props #(.CW(CW), .SW(SW), .AW(AW)) u_props (
   .clk(clk), .nrst(nrst), .core_held_reset(core_held_reset), .reg_sel(reg_sel),
   .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .reg_ack(reg_ack), .match_pending_irq(match_pending_irq),
   .guard_reset_req(guard_reset_req), .unlocked(unlocked), .write_ignored(write_ignored));

// >>> bench/tb_always_on_watchdog_timer.sv
`timescale 1ns/1ps
`include "aowdt_regs.vh"
module tb_always_on_watchdog_timer;
   localparam [8:0] CFG = `AOWDT_OFS_CONFIG;
   localparam [8:0] CNT = `AOWDT_OFS_COUNT;
   localparam [8:0] CMP = `AOWDT_OFS_THRESHOLD;
   logic        clk = 1'b0;
   logic        nrst = 1'b0;
   logic        sel = 1'b0;
   logic        wr = 1'b0;
   logic [8:0]  addr = 9'h0;
   logic [31:0] wdata = 32'h0;
   logic        sleep_cmd = 1'b0;
   logic [31:0] d, a;
   wire  [31:0] rdata;
   wire         ack, irq, rreq, unl, ign, core_rst;
   int          n_fail = 0;
   int          total_checks = 0;
   logic [3:0]  sc [3] = '{4'h0, 4'h4, 4'hf};
   logic [31:0] cv [3] = '{32'h12345, 32'h12345, 32'h7fff8000};

   always #10 clk = ~clk;

   aowdt_timer dut_u (.clk(clk), .nrst(nrst), .core_held_reset(core_rst), .reg_sel(sel),
      .reg_wr(wr), .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata), .reg_ack(ack),
      .match_pending_irq(irq), .guard_reset_req(rreq), .unlocked(unl), .write_ignored(ign));
   aowdt_sleep_model u_sleep (.clk(clk), .nrst(nrst), .sleep_cmd(sleep_cmd),
      .core_held_reset(core_rst));

   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // One bus access; answer sampled once the answering edge has settled
   task acc(input logic w, input logic [8:0] ad, input logic [31:0] v);
      @(posedge clk);
      #1 sel = 1'b1;
      wr = w;
      addr = ad;
      wdata = v;
      @(posedge clk);
      #1 sel = 1'b0;
      chk("ack", {31'h0, ack}, 32'h1);
      d = rdata;
   endtask
   // Every protected write needs a fresh unlock
   task uw(input logic [8:0] ad, input logic [31:0] v);
      acc(1'b1, `AOWDT_OFS_UNLOCK, `AOWDT_UNLOCK_VALUE);
      acc(1'b1, ad, v);
   endtask
   task rst;
      nrst = 1'b0;
      repeat (8) @(posedge clk);
      #1 nrst = 1'b1;
   endtask
   task end_sim;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // Cuts a hang short
   initial begin
      #100000;
      n_fail++;
      end_sim;
   end

   // Main sequence
   initial begin
      rst;
      acc(0, CFG, 0); chk("cfg", d, 32'h0);
      acc(0, CMP, 0); chk("thr", d, 32'hffff);
      acc(1, CFG, 32'h1000); chk("ign", {31'h0, ign}, 32'h1);
      acc(0, CFG, 0); chk("cfg", d, 32'h0);
      acc(1, `AOWDT_OFS_UNLOCK, `AOWDT_UNLOCK_VALUE); chk("unl", {31'h0, unl}, 32'h1);
      acc(1, CMP, 32'habcd0010); chk("unl", {31'h0, unl}, 32'h0);
      acc(0, CMP, 0); chk("thr", d, 32'h10);
      $display("test lock done");
      // Comparator boundary and sticky pending
      uw(CNT, 32'h8000000f); acc(0, CNT, 0); chk("cnt", d, 32'hf);
      chk("irq", {31'h0, irq}, 32'h0);
      uw(CNT, 32'h10); acc(0, CFG, 0); chk("irq", {31'h0, irq}, 32'h1);
      chk("rreq", {31'h0, rreq}, 32'h0);
      uw(CNT, 0); acc(0, CFG, 0); chk("pend", d, 32'h10000000);
      uw(CFG, 0); acc(0, CFG, 0); chk("irq", {31'h0, irq}, 32'h0);
      $display("test compare done");
      // Feed with wrong and right values, unmapped access
      uw(CNT, 32'h5); uw(`AOWDT_OFS_FEED, 32'h1234);
      acc(0, CNT, 0); chk("cnt", d, 32'h5);
      uw(`AOWDT_OFS_FEED, `AOWDT_FEED_VALUE); acc(0, CNT, 0); chk("cnt", d, 32'h0);
      acc(0, `AOWDT_OFS_FEED, 0); chk("feed", d, 32'h0);
      acc(1, `AOWDT_OFS_UNLOCK, `AOWDT_UNLOCK_VALUE); acc(1, 9'h100, 32'h1);
      chk("unl", {31'h0, unl}, 32'h1);
      acc(0, 9'h100, 0); chk("unmapped", d, 32'h0);
      uw(CFG, 32'hefffccf3); acc(0, CFG, 0); chk("cfg", d, 32'h3);
      $display("test feed done");
      // Scaled window for each boundary of the scale field
      for (int i = 0; i < 3; i++) begin
         uw(CNT, cv[i]);
         uw(CFG, {28'h0, sc[i]});
         acc(0, `AOWDT_OFS_SCALED, 0); chk("scaled", d, (cv[i] >> sc[i]) & 32'hffff);
      end
      $display("test scale done");
      // Increment qualifiers
      uw(CMP, 32'hffff); uw(CNT, 0); uw(CFG, 32'h1000);
      acc(0, CNT, 0); a = d; acc(0, CNT, 0); chk("step", d - a, 32'h2);
      sleep_cmd = 1'b1; uw(CFG, 32'h2000); repeat (2) @(posedge clk);
      acc(0, CNT, 0); a = d; acc(0, CNT, 0); chk("sleep", d - a, 32'h0);
      sleep_cmd = 1'b0; repeat (2) @(posedge clk);
      acc(0, CNT, 0); a = d; acc(0, CNT, 0); chk("awake", d - a, 32'h2);
      $display("test run done");
      // Periodic mode: auto-zero keeps the count at or under the threshold
      uw(CMP, 32'h8); uw(CNT, 0); uw(CFG, 32'h1200); repeat (30) @(posedge clk);
      for (int i = 0; i < 5; i++) begin
         acc(0, CNT, 0); chk("wrap", {31'h0, d <= 32'h8}, 32'h1);
      end
      chk("irq", {31'h0, irq}, 32'h1);
      chk("rreq", {31'h0, rreq}, 32'h0);
      // Reset firing, then a second reset clears the enables
      uw(CFG, 32'h1100);
      for (int k = 0; k < 40; k++)
         if (rreq !== 1'b1) @(posedge clk);
      #1 chk("rreq", {31'h0, rreq}, 32'h1);
      rst;
      acc(0, CFG, 0); chk("cfg", d, 32'h0);
      chk("rreq", {31'h0, rreq}, 32'h0);
      $display("test fire done");
      end_sim;
   end
endmodule // tb_always_on_watchdog_timer
